// ===== hw/fws_host.sv
// Purpose: Host controller that sequences commands into the flash and polls its toggle status bits
// Assumes: Software drives it over classic Wishbone; flash strobes and data bus are pins
// Notes: One operation at a time; CTRL writes while busy or under supply lockout are ignored
`timescale 1ns/10ps
module fws_host (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] wbAdr,
    input wire logic [31:0] wbDatW,
    output logic [31:0] wbDatR,
    input wire logic wbWe,
    input wire logic [3:0] wbSel,
    input wire logic wbCyc,
    input wire logic wbStb,
    output logic wbAck,
    output fws_pkg::fws_pins_t flashPins,
    output logic flashRstN,
    output logic [15:0] dqOut,
    output logic dqOe,
    input wire logic [15:0] dqIn,
    input wire logic supplyOk
);

    typedef enum {ST_IDLE, ST_WSETUP, ST_WLOW, ST_WHIGH, ST_RLOW, ST_RGAP, ST_NEXT} fws_state_t;
    typedef enum {PH_CMD, PH_READ, PH_PRE, PH_POST, PH_POLL, PH_RESET} fws_phase_t;

    fws_state_t state;
    fws_phase_t phase;
    fws_pkg::fws_op_t op;
    logic [19:0] regAddr;
    logic [15:0] regWdata;
    logic [15:0] regRdata;
    logic [15:0] prevWord;
    logic [15:0] dqMeta;
    logic [15:0] dqSync;
    logic supplyMeta;
    logic supplySync;
    logic [5:0] waitCnt;
    logic [2:0] stepIdx;
    logic pollSecond;
    logic limitSeen;
    logic busy;
    logic done;
    logic fail;
    logic dropped;
    logic goReq;
    fws_pkg::fws_step_t step;

    // ========================================================
    // Input synchronisers; first stage feeds only the second
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dqMeta <= 16'h0000;
            dqSync <= 16'h0000;
            supplyMeta <= 1'b0;
            supplySync <= 1'b0;
        end else begin
            dqMeta <= dqIn;
            dqSync <= dqMeta;
            supplyMeta <= supplyOk;
            supplySync <= supplyMeta;
        end
    end

    // ========================================================
    // Command table; program and both erase ops span several cycles, an added sector cycle is one write
    always_comb begin
        step = '{addr: regAddr, data: fws_pkg::FWS_RESET_DATA, last: 1'b1};
        case (op)
            fws_pkg::FWS_OP_PROGRAM: begin
                case (stepIdx)
                    3'd0: step = '{addr: fws_pkg::FWS_UNLOCK1_ADDR, data: fws_pkg::FWS_UNLOCK1_DATA, last: 1'b0};
                    3'd1: step = '{addr: fws_pkg::FWS_UNLOCK2_ADDR, data: fws_pkg::FWS_UNLOCK2_DATA, last: 1'b0};
                    3'd2: step = '{addr: fws_pkg::FWS_UNLOCK1_ADDR, data: fws_pkg::FWS_PROGRAM_DATA, last: 1'b0};
                    default: step = '{addr: regAddr, data: regWdata, last: 1'b1};
                endcase
            end
            fws_pkg::FWS_OP_SECTOR_ERASE, fws_pkg::FWS_OP_CHIP_ERASE: begin
                case (stepIdx)
                    3'd0, 3'd3: step = '{addr: fws_pkg::FWS_UNLOCK1_ADDR, data: fws_pkg::FWS_UNLOCK1_DATA, last: 1'b0};
                    3'd1, 3'd4: step = '{addr: fws_pkg::FWS_UNLOCK2_ADDR, data: fws_pkg::FWS_UNLOCK2_DATA, last: 1'b0};
                    3'd2: step = '{addr: fws_pkg::FWS_UNLOCK1_ADDR, data: fws_pkg::FWS_ERASE_DATA, last: 1'b0};
                    default: begin
                        if (op == fws_pkg::FWS_OP_CHIP_ERASE) begin
                            step = '{addr: fws_pkg::FWS_UNLOCK1_ADDR, data: fws_pkg::FWS_CHIP_DATA, last: 1'b1};
                        end else begin
                            step = '{addr: regAddr, data: fws_pkg::FWS_SECTOR_DATA, last: 1'b1};
                        end
                    end
                endcase
            end
            fws_pkg::FWS_OP_ERASE_ADD, fws_pkg::FWS_OP_RESUME: begin
                step = '{addr: regAddr, data: fws_pkg::FWS_SECTOR_DATA, last: 1'b1};
            end
            fws_pkg::FWS_OP_SUSPEND: begin
                step = '{addr: regAddr, data: fws_pkg::FWS_SUSPEND_DATA, last: 1'b1};
            end
            default: begin
                step = '{addr: regAddr, data: fws_pkg::FWS_RESET_DATA, last: 1'b1};
            end
        endcase
        if (phase == PH_RESET) begin
            step = '{addr: regAddr, data: fws_pkg::FWS_RESET_DATA, last: 1'b1};
        end
    end

    // ========================================================
    // Wishbone slave; ack one cycle after request, dropped next cycle
    assign goReq = wbCyc && wbStb && !wbAck && wbWe && wbSel[0] && (wbAdr == fws_pkg::FWS_REG_CTRL);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wbAck <= 1'b0;
            wbDatR <= 32'h00000000;
            regAddr <= 20'h00000;
            regWdata <= 16'h0000;
        end else begin
            wbAck <= wbCyc && wbStb && !wbAck;
            if (wbCyc && wbStb && !wbAck && wbWe && !busy) begin
                // Address and data are frozen while an operation runs
                if (wbAdr == fws_pkg::FWS_REG_ADDR) begin
                    regAddr <= wbDatW[19:0];
                end else if (wbAdr == fws_pkg::FWS_REG_WDATA) begin
                    regWdata <= wbDatW[15:0];
                end
            end
            if (wbAdr == fws_pkg::FWS_REG_CTRL) begin
                wbDatR <= {28'h0000000, op};
            end else if (wbAdr == fws_pkg::FWS_REG_ADDR) begin
                wbDatR <= {12'h000, regAddr};
            end else if (wbAdr == fws_pkg::FWS_REG_WDATA) begin
                wbDatR <= {16'h0000, regWdata};
            end else if (wbAdr == fws_pkg::FWS_REG_RDATA) begin
                wbDatR <= {16'h0000, regRdata};
            end else if (wbAdr == fws_pkg::FWS_REG_STATUS) begin
                wbDatR <= {26'h0000000, regRdata[3], !supplySync, dropped, fail, done, busy};
            end else begin
                wbDatR <= 32'h00000000;
            end
        end
    end

    // ========================================================
    // Pin sequencer and poll algorithm
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            // Strobes held high through reset so no power-up write is seen
            state <= ST_IDLE;
            phase <= PH_CMD;
            op <= fws_pkg::FWS_OP_READ;
            flashPins <= fws_pkg::FWS_PINS_IDLE;
            flashRstN <= 1'b0;
            dqOut <= 16'h0000;
            dqOe <= 1'b0;
            waitCnt <= 6'h00;
            stepIdx <= 3'h0;
            pollSecond <= 1'b0;
            limitSeen <= 1'b0;
            prevWord <= 16'h0000;
            regRdata <= 16'h0000;
            busy <= 1'b0;
            done <= 1'b0;
            fail <= 1'b0;
            dropped <= 1'b0;
        end else begin
            flashRstN <= 1'b1;
            if (waitCnt != 6'h00) begin
                waitCnt <= waitCnt - 6'h01;
            end
            if (!supplySync && state != ST_IDLE) begin
                // Abandon the operation; never strobe a write under lockout
                state <= ST_IDLE;
                busy <= 1'b0;
                fail <= 1'b1;
                dqOe <= 1'b0;
                flashPins <= fws_pkg::FWS_PINS_IDLE;
            end else begin
                case (state)
                    ST_IDLE: begin
                        if (goReq && !busy && supplySync) begin
                            op <= fws_fwd(wbDatW[3:0]);
                            busy <= 1'b1;
                            done <= 1'b0;
                            fail <= 1'b0;
                            dropped <= 1'b0;
                            stepIdx <= 3'h0;
                            pollSecond <= 1'b0;
                            limitSeen <= 1'b0;
                            state <= ST_NEXT;
                            if (wbDatW[3:0] == fws_pkg::FWS_OP_READ) begin
                                phase <= PH_READ;
                                state <= ST_RGAP;
                            end else if (wbDatW[3:0] == fws_pkg::FWS_OP_POLL) begin
                                phase <= PH_POLL;
                                state <= ST_RGAP;
                            end else if (wbDatW[3:0] == fws_pkg::FWS_OP_ERASE_ADD) begin
                                phase <= PH_PRE; // Bit 3 checked before the data cycle
                                state <= ST_RGAP;
                            end else begin
                                phase <= PH_CMD;
                                state <= ST_WSETUP;
                            end
                        end
                    end
                    ST_WSETUP: begin
                        // Address and data settle with output strobe high
                        flashPins <= '{ceN: 1'b0, oeN: 1'b1, weN: 1'b1, addr: step.addr};
                        dqOut <= step.data;
                        dqOe <= 1'b1;
                        waitCnt <= fws_pkg::FWS_WPULSE_CYC;
                        state <= ST_WLOW;
                    end
                    ST_WLOW: begin
                        // Runs down to zero so the low time is never one cycle short of the minimum
                        flashPins.weN <= 1'b0;
                        if (waitCnt == 6'h00) begin
                            flashPins.weN <= 1'b1;
                            waitCnt <= fws_pkg::FWS_WHIGH_CYC;
                            state <= ST_WHIGH;
                        end
                    end
                    ST_WHIGH: begin
                        // Data held past the rising write edge, then released
                        if (waitCnt == 6'h01) begin
                            flashPins.ceN <= 1'b1;
                            dqOe <= 1'b0;
                            state <= ST_NEXT;
                        end
                    end
                    ST_RGAP: begin
                        // Output strobe high gap separates status reads
                        flashPins <= '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1, addr: regAddr};
                        dqOe <= 1'b0;
                        waitCnt <= fws_pkg::FWS_OEHIGH_CYC;
                        state <= ST_RLOW;
                    end
                    ST_RLOW: begin
                        if (flashPins.ceN && waitCnt == 6'h01) begin
                            flashPins.ceN <= 1'b0;
                            flashPins.oeN <= 1'b0;
                            waitCnt <= fws_pkg::FWS_ACCESS_CYC + 6'h02; // Plus synchroniser delay
                        end else if (!flashPins.ceN && waitCnt == 6'h01) begin
                            regRdata <= dqSync; // Busy bank answers with status
                            flashPins.ceN <= 1'b1;
                            flashPins.oeN <= 1'b1;
                            state <= ST_NEXT;
                        end
                    end
                    default: begin
                        // ST_NEXT: decide the following cycle
                        state <= ST_IDLE;
                        busy <= 1'b0;
                        done <= 1'b1;
                        case (phase)
                            PH_CMD: begin
                                if (!step.last) begin
                                    stepIdx <= stepIdx + 3'h1;
                                    busy <= 1'b1;
                                    done <= 1'b0;
                                    state <= ST_WSETUP;
                                end else if (op == fws_pkg::FWS_OP_PROGRAM || op == fws_pkg::FWS_OP_CHIP_ERASE) begin
                                    phase <= PH_POLL; // Status valid after last write edge
                                    busy <= 1'b1;
                                    done <= 1'b0;
                                    state <= ST_RGAP;
                                end else if (op == fws_pkg::FWS_OP_ERASE_ADD) begin
                                    phase <= PH_POST;
                                    busy <= 1'b1;
                                    done <= 1'b0;
                                    state <= ST_RGAP;
                                end
                            end
                            PH_PRE: begin
                                if (regRdata[3]) begin
                                    dropped <= 1'b1; // Timer expired, cycle would be ignored
                                end else begin
                                    phase <= PH_CMD;
                                    busy <= 1'b1;
                                    done <= 1'b0;
                                    state <= ST_WSETUP;
                                end
                            end
                            PH_POST: begin
                                dropped <= regRdata[3]; // High after the cycle may mean dropped
                            end
                            PH_POLL: begin
                                busy <= 1'b1;
                                done <= 1'b0;
                                state <= ST_RGAP;
                                prevWord <= regRdata;
                                pollSecond <= 1'b1;
                                if (pollSecond) begin
                                    if (regRdata[6] == prevWord[6]) begin
                                        // Toggle stopped: algorithm finished
                                        busy <= 1'b0;
                                        done <= 1'b1;
                                        state <= ST_IDLE;
                                    end else if (limitSeen) begin
                                        // Still toggling after the limit flag: failed
                                        fail <= 1'b1;
                                        phase <= PH_RESET;
                                        state <= ST_WSETUP;
                                    end else if (regRdata[5]) begin
                                        // Bit 5 trusted only while toggling; reread pair
                                        limitSeen <= 1'b1;
                                        pollSecond <= 1'b0;
                                    end
                                end
                            end
                            PH_RESET: begin
                                fail <= 1'b1; // Reset command returns device to read
                            end
                            default: begin
                            end
                        endcase
                    end
                endcase
            end
        end
    end

    // ========================================================
    // Opcode decode; unknown codes map to FWS_OP_READ, but CTRL starts them as commands, so the reset cycle is written
    function automatic fws_pkg::fws_op_t fws_fwd(input logic [3:0] code);
        fws_pkg::fws_op_t result;
        result = fws_pkg::FWS_OP_READ;
        if (code <= 4'h8) begin
            result = fws_pkg::fws_op_t'(code);
        end
        return result;
    endfunction

endmodule

// ===== shared/fws_pkg.sv
// Purpose: Constants, types and command tables for the flash status and write-inhibit host controller
// Assumes: 250 MHz clock, word-wide asynchronous flash, classic Wishbone register port
// Notes: Unlock addresses and command data are plain defaults; adjust them for the attached part
//
// Contract
// - Toggle status valid after last write strobe; reads paced by OE or CE.
// - Host trusts bit 5 only while bit 7 or 6 shows busy.
// - After a bit 5 failure host issues reset; device returns to read.
// - Host checks bit 3 before and after each added sector cycle.
// - Write only with chip select and write strobe low, output strobe high.
// - Array-altering commands are sent as multi-cycle sequences only; the host sends added sector and resume cycles as single writes.
package fws_pkg;

    // ========================================================
    // Register map (byte addresses)
    localparam logic [7:0] FWS_REG_CTRL = 8'h00;
    localparam logic [7:0] FWS_REG_ADDR = 8'h04;
    localparam logic [7:0] FWS_REG_WDATA = 8'h08;
    localparam logic [7:0] FWS_REG_RDATA = 8'h0C;
    localparam logic [7:0] FWS_REG_STATUS = 8'h10;

    // Status field positions
    localparam int FWS_ST_BUSY = 0;
    localparam int FWS_ST_DONE = 1;
    localparam int FWS_ST_FAIL = 2;
    localparam int FWS_ST_DROPPED = 3;
    localparam int FWS_ST_LOCKOUT = 4;
    localparam int FWS_ST_ERASETIMER = 5;

    // ========================================================
    // Pin timing in ns and derived cycle counts (least times round up)
    localparam int FWS_CLK_MHZ = 250;
    localparam int FWS_ACCESS_NS = 120;
    localparam int FWS_WPULSE_NS = 50;
    localparam int FWS_WHIGH_NS = 30;
    localparam int FWS_OEHIGH_NS = 20;
    localparam logic [5:0] FWS_ACCESS_CYC = 6'((FWS_ACCESS_NS * FWS_CLK_MHZ + 999) / 1000);
    localparam logic [5:0] FWS_WPULSE_CYC = 6'((FWS_WPULSE_NS * FWS_CLK_MHZ + 999) / 1000);
    localparam logic [5:0] FWS_WHIGH_CYC = 6'((FWS_WHIGH_NS * FWS_CLK_MHZ + 999) / 1000);
    localparam logic [5:0] FWS_OEHIGH_CYC = 6'((FWS_OEHIGH_NS * FWS_CLK_MHZ + 999) / 1000);

    // ========================================================
    // Command cycles
    localparam logic [19:0] FWS_UNLOCK1_ADDR = 20'h00555;
    localparam logic [19:0] FWS_UNLOCK2_ADDR = 20'h002AA;
    localparam logic [15:0] FWS_UNLOCK1_DATA = 16'h00AA;
    localparam logic [15:0] FWS_UNLOCK2_DATA = 16'h0055;
    localparam logic [15:0] FWS_PROGRAM_DATA = 16'h00A0;
    localparam logic [15:0] FWS_ERASE_DATA = 16'h0080;
    localparam logic [15:0] FWS_SECTOR_DATA = 16'h0030;
    localparam logic [15:0] FWS_CHIP_DATA = 16'h0010;
    localparam logic [15:0] FWS_SUSPEND_DATA = 16'h00B0;
    localparam logic [15:0] FWS_RESET_DATA = 16'h00F0;

    typedef enum logic [3:0] {
        FWS_OP_READ = 4'h0,
        FWS_OP_PROGRAM = 4'h1,
        FWS_OP_SECTOR_ERASE = 4'h2,
        FWS_OP_CHIP_ERASE = 4'h3,
        FWS_OP_ERASE_ADD = 4'h4,
        FWS_OP_SUSPEND = 4'h5,
        FWS_OP_RESUME = 4'h6,
        FWS_OP_RESET = 4'h7,
        FWS_OP_POLL = 4'h8
    } fws_op_t;

    // Flash strobe and address pins, all active-low strobes
    typedef struct packed {
        logic ceN;
        logic oeN;
        logic weN;
        logic [19:0] addr;
    } fws_pins_t;

    localparam fws_pins_t FWS_PINS_IDLE = '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1, addr: 20'h00000};

    // One bus cycle of a command sequence
    typedef struct packed {
        logic [19:0] addr;
        logic [15:0] data;
        logic last;
    } fws_step_t;

endpackage

// ===== test/fws_host_asserts.sv
// Purpose: Port checker for the flash host controller
// Assumes: One clock domain, reset high
// Notes: Bound to every fws_host instance
`timescale 1ns/10ps
module fws_host_asserts (
    input wire logic clock,
    input wire logic rst,
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbAck,
    input wire fws_pkg::fws_pins_t flashPins,
    input wire logic flashRstN,
    input wire logic dqOe,
    input wire logic supplyOk
);
    // ==========================================
    // Bus and pin relations
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    ack_one_cycle_a: assert property (wbCyc && wbStb && !wbAck |=> wbAck ##1 !wbAck) else $error("ack timing");
    ack_needs_req_a: assert property (!(wbCyc && wbStb) |=> !wbAck) else $error("ack without request");
    write_inhibit_a: assert property (!flashPins.weN |-> !flashPins.ceN && flashPins.oeN) else $error("bad write");
    write_pulse_a: assert property ($fell(flashPins.weN) |-> (!flashPins.weN)[*8] ##5 !flashPins.weN ##1 flashPins.weN)
        else $error("write pulse length");
    supply_lock_a: assert property ((!supplyOk)[*5] |-> flashPins.weN && flashPins.ceN) else $error("lockout");
    no_contention_a: assert property (dqOe |-> flashPins.oeN) else $error("dq contention");
    read_strobe_a: assert property ($fell(flashPins.oeN) |-> (!flashPins.oeN && !flashPins.ceN)[*8] ##23 !flashPins.oeN)
        else $error("read pulse");
    addr_hold_a: assert property (!flashPins.ceN && !$past(flashPins.ceN) |-> $stable(flashPins.addr))
        else $error("address moved");
    pin_reset_a: assert property ($fell(rst) |=> flashRstN) else $error("flash reset");
endmodule
bind fws_host fws_host_asserts i_chk (.clock(clock), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbAck(wbAck),
    .flashPins(flashPins), .flashRstN(flashRstN), .dqOe(dqOe), .supplyOk(supplyOk));

// ===== test/fws_flash_model.sv
// Purpose: Behavioural flash with toggle status bits
// Assumes: Busy spans a fixed count of status reads, not real time
// Notes: One array word; unlock addresses not checked
`timescale 1ns/10ps
module fws_flash_model (
    input wire fws_pkg::fws_pins_t pins,
    input wire logic rstN,
    input wire logic supplyOk,
    input wire logic [15:0] dqOut,
    input wire logic dqOe,
    output logic [15:0] dqIn
);
    logic busy = 1'b0, fail = 1'b0, tog = 1'b0, tog2 = 1'b0, ers = 1'b0;
    logic [15:0] arr = 16'hFFFF, pdat = 16'h0000, last = 16'h0000;
    int step = 0, rd = 0, lim = 0;
    wire rdAct = !pins.ceN && !pins.oeN;
    // ==========================================
    // Status word while busy, array otherwise
    wire [15:0] stat = {8'h00, !ers && !pdat[7], tog, fail, 1'b0, ers && rd >= 3, tog2, 2'b00};
    wire [15:0] word = busy ? stat : arr;
    // Released bus shows inverse of last word, so a stale value never passes
    assign dqIn = rdAct ? word : dqOe ? dqOut : ~last;
    always @(negedge rdAct) last = word;
    // Read start advances toggles; a failed run toggles until reset
    always @(posedge rdAct) begin
        if (busy && !fail && rd >= lim) begin
            busy = 1'b0;
        end else if (busy) begin
            tog = ~tog;
            tog2 = tog2 ^ ers;
            rd++;
        end
    end
    // ==========================================
    // Command cycles latch on the write strobe rising edge
    always @(posedge pins.weN or negedge rstN or negedge supplyOk) begin
        if (!rstN || !supplyOk) begin
            busy = 1'b0;
            fail = 1'b0;
            step = 0;
        end else if (!pins.ceN && pins.oeN && supplyOk) begin
            if (dqOut == fws_pkg::FWS_RESET_DATA) begin
                busy = 1'b0;
                fail = 1'b0;
                step = 0;
            end else if (!busy) begin
                // Sector cycles while busy are absorbed: one shared busy span
                case (step)
                    0, 1, 4, 5: step = (dqOut == (step % 2 ? 16'h0055 : 16'h00AA)) ? step + 1 : 0;
                    2: step = dqOut == fws_pkg::FWS_PROGRAM_DATA ? 3 : dqOut == fws_pkg::FWS_ERASE_DATA ? 4 : 0;
                    3: begin
                        fail = |(dqOut & ~arr);
                        arr = fail ? arr : arr & dqOut;
                        {pdat, ers, lim, rd, busy, step} = {dqOut, 1'b0, 32'd4, 32'd0, 1'b1, 32'd0};
                    end
                    6: begin
                        ers = 1'b1;
                        busy = dqOut == fws_pkg::FWS_SECTOR_DATA || dqOut == fws_pkg::FWS_CHIP_DATA;
                        arr = busy ? 16'hFFFF : arr;
                        lim = dqOut == fws_pkg::FWS_SECTOR_DATA ? 7 : 4;
                        {rd, step} = {32'd0, 32'd0};
                    end
                    default: step = 0;
                endcase
            end
        end
    end
endmodule

// ===== test/tb_fws_host.sv
// Purpose: Self-checking bench for the flash host controller
// Assumes: Flash model answers status for a fixed number of reads
// Notes: Each scenario is one task
`timescale 1ns/10ps
module tb_fws_host;
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; $display("Error %s exp %h got %h", nm, e, g); end end
    logic clock = 1'b0, rst = 1'b1, wbWe = 1'b0, wbCyc = 1'b0, wbStb = 1'b0, supplyOk = 1'b1, wbAck, flashRstN, dqOe;
    logic [7:0] wbAdr = 8'h00;
    logic [31:0] wbDatW = 32'h0, wbDatR, q;
    logic [15:0] dqOut, dqIn;
    fws_pkg::fws_pins_t flashPins;
    int bad_count = 0, cmp_count = 0;
    always #2 clock = ~clock;
    fws_host i_dut (.clock(clock), .rst(rst), .wbAdr(wbAdr), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbWe(wbWe),
        .wbSel(4'hF), .wbCyc(wbCyc), .wbStb(wbStb), .wbAck(wbAck), .flashPins(flashPins), .flashRstN(flashRstN),
        .dqOut(dqOut), .dqOe(dqOe), .dqIn(dqIn), .supplyOk(supplyOk));
    fws_flash_model i_flash (.pins(flashPins), .rstN(flashRstN), .supplyOk(supplyOk), .dqOut(dqOut), .dqOe(dqOe),
        .dqIn(dqIn));
    // ==========================================
    // Classic Wishbone cycle: hold until ack is sampled
    task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d);
        int n = 0;
        {wbAdr, wbWe, wbDatW, wbCyc, wbStb} <= {a, we, d, 2'b11};
        @(posedge clock);
        while (wbAck !== 1'b1 && n < 100) begin
            @(posedge clock);
            n++;
        end
        if (n >= 100) begin
            bad_count++;
            $display("Error wbAck exp 1 got 0");
        end
        q = wbDatR;
        {wbCyc, wbStb} <= 2'b00;
        @(posedge clock);
    endtask
    // Start an op, then poll STATUS until busy drops; q ends as STATUS
    task automatic run_op(input fws_pkg::fws_op_t op, input logic [31:0] d);
        int n = 0;
        wb(fws_pkg::FWS_REG_ADDR, 1'b1, 32'h100);
        wb(fws_pkg::FWS_REG_WDATA, 1'b1, d);
        wb(fws_pkg::FWS_REG_CTRL, 1'b1, 32'(op));
        do begin
            wb(fws_pkg::FWS_REG_STATUS, 1'b0, 32'h0);
            n++;
        end while (q[0] === 1'b1 && n < 3000);
        if (q[0] !== 1'b0) begin
            bad_count++;
            $display("Error busy exp 0 got %b", q[0]);
        end
    endtask
    task automatic rdata(input logic [15:0] e);
        run_op(fws_pkg::FWS_OP_READ, 32'h0);
        wb(fws_pkg::FWS_REG_RDATA, 1'b0, 32'h0);
        `CHK("rdata", {16'h0, e}, q)
    endtask
    // ==========================================
    // Scenarios
    task automatic t_idle;
        wb(fws_pkg::FWS_REG_STATUS, 1'b0, 32'h0);
        `CHK("status", 32'h0, q)
        wb(8'h20, 1'b0, 32'h0);
        `CHK("unmapped", 32'h0, q)
        $display("t_idle done");
    endtask
    task automatic t_prog;
        run_op(fws_pkg::FWS_OP_PROGRAM, 32'h1234);
        `CHK("prog", 3'b010, q[2:0])
        rdata(16'h1234);
        run_op(fws_pkg::FWS_OP_PROGRAM, 32'h00FF); // one over zero must fail
        `CHK("overwrite", 3'b110, q[2:0])
        rdata(16'h1234);
        $display("t_prog done");
    endtask
    task automatic t_erase;
        logic bit2;
        run_op(fws_pkg::FWS_OP_SECTOR_ERASE, 32'h0);
        `CHK("erase go", 3'b010, q[2:0])
        run_op(fws_pkg::FWS_OP_ERASE_ADD, 32'h0);
        `CHK("add taken", 1'b0, q[3])
        wb(fws_pkg::FWS_REG_RDATA, 1'b0, 32'h0);
        `CHK("erase word", 3'b000, {q[7], q[5], q[3]})
        bit2 = q[2];
        run_op(fws_pkg::FWS_OP_ERASE_ADD, 32'h0);
        `CHK("add dropped", 2'b11, {q[5], q[3]})
        wb(fws_pkg::FWS_REG_RDATA, 1'b0, 32'h0);
        `CHK("toggle two", ~bit2, q[2])
        run_op(fws_pkg::FWS_OP_POLL, 32'h0);
        `CHK("erase poll", 3'b010, q[2:0])
        rdata(16'hFFFF);
        run_op(fws_pkg::FWS_OP_CHIP_ERASE, 32'h0);
        `CHK("chip", 3'b010, q[2:0])
        $display("t_erase done");
    endtask
    task automatic t_lock;
        supplyOk <= 1'b0;
        repeat (6) @(posedge clock);
        run_op(fws_pkg::FWS_OP_PROGRAM, 32'h0);
        `CHK("lockout", 2'b10, {q[4], q[0]})
        supplyOk <= 1'b1;
        repeat (4) @(posedge clock);
        rdata(16'hFFFF);
        $display("t_lock done");
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        repeat (3) @(posedge clock);
        t_idle();
        t_prog();
        t_erase();
        t_lock();
        end_sim();
    end
    // Watchdog well past the roughly two thousand cycles the tests take
    initial begin
        #200000;
        bad_count++;
        end_sim();
    end
endmodule
